// ==== design/sbc_wd_pkg.sv ====
// Shared constants and types for the watchdog and main status block
package sbc_wd_pkg;
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned TICK_US         = 1000;
   localparam int unsigned TICK_CYCLES_DEF = (CLK_HZ / 1_000_000) * TICK_US;
   localparam int unsigned MS_W            = 13;

   localparam logic [6:0] ADDR_WD_CTRL     = 7'h00;
   localparam logic [6:0] ADDR_MAIN_STATUS = 7'h03;
   localparam logic [6:0] ADDR_WD_STATUS   = 7'h05;

   localparam int unsigned MODE_MSB  = 7;
   localparam int unsigned MODE_LSB  = 5;
   localparam int unsigned PER_MSB   = 3;
   localparam int unsigned PER_LSB   = 0;
   localparam int unsigned OTW_BIT   = 6;
   localparam int unsigned NYN_BIT   = 5;
   localparam int unsigned FNM_BIT   = 3;
   localparam int unsigned SDM_BIT   = 2;

   localparam logic [2:0] WMC_AUTO    = 3'h1;
   localparam logic [2:0] WMC_TIMEOUT = 3'h2;
   localparam logic [2:0] WMC_WINDOW  = 3'h4;
   localparam logic [3:0] NWP_DEFAULT = 4'h4;

   localparam logic [1:0] WDS_OFF    = 2'h0;
   localparam logic [1:0] WDS_FIRST  = 2'h1;
   localparam logic [1:0] WDS_SECOND = 2'h2;

   localparam logic [4:0] CAUSE_POWER_ON    = 5'h00;
   localparam logic [4:0] CAUSE_CAN_WAKE    = 5'h01;
   localparam logic [4:0] CAUSE_PIN_WAKE    = 5'h04;
   localparam logic [4:0] CAUSE_SLEEP_OVF   = 5'h0C;
   localparam logic [4:0] CAUSE_DIAG_WAKE   = 5'h0D;
   localparam logic [4:0] CAUSE_EARLY_TRIG  = 5'h0E;
   localparam logic [4:0] CAUSE_WD_OVF      = 5'h0F;
   localparam logic [4:0] CAUSE_ILLEGAL_WMC = 5'h10;
   localparam logic [4:0] CAUSE_PIN_PULL    = 5'h11;
   localparam logic [4:0] CAUSE_OT_EXIT     = 5'h12;
   localparam logic [4:0] CAUSE_V1_UV       = 5'h13;
   localparam logic [4:0] CAUSE_BAD_SLEEP   = 5'h14;

   typedef enum logic [2:0] {
      CM_OFF, CM_FORCED_NORMAL, CM_STANDBY, CM_NORMAL, CM_SLEEP, CM_RESET, CM_OVERTEMP
   } chip_mode_t;

   typedef enum logic [1:0] {WD_OFF, WD_TIMEOUT, WD_WINDOW} wd_beh_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic can_wake;
      logic pin_wake;
      logic diag_wake;
      logic pin_pulldown;
      logic overtemp_exit;
      logic v1_undervoltage;
      logic bad_sleep_cmd;
   } cause_ev_t;
endpackage

// ==== design/level_sync.sv ====
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   generate
      if (WIDTH < 1) begin : g_chk
         $error("level_sync WIDTH must be at least 1");
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (reset) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // level_sync
`default_nettype wire

// ==== design/ms_tick.sv ====
// Restartable time base giving one pulse per millisecond
`timescale 1ns/1ps
`default_nettype none
module ms_tick #(
   parameter int unsigned CYCLES = sbc_wd_pkg::TICK_CYCLES_DEF
) (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic restart,
   output var  logic tick_q
);
   localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [CW-1:0] cnt_q;

   generate
      if (CYCLES < 2) begin : g_chk
         $error("ms_tick CYCLES must be at least 2");
      end
   endgenerate

   // Restart realigns the phase so a full period follows each trigger
   always_ff @(posedge clk) begin
      if (reset || restart) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else if (cnt_q == LAST) begin
         cnt_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + CW'(1);
         tick_q <= 1'b0;
      end
   end
endmodule // ms_tick
`default_nettype wire

// ==== design/sbc_watchdog_reset_status.sv ====
// Watchdog unit with main status and reset cause recording
// Summary of operation
// - Status bit 6 shows overtemperature warning level
// - Status bit 5 set until first Normal
// - Wake causes coded 00001, 00100, 01101
// - Watchdog causes coded 01100, 01110, 01111
// - Pin, overtemp exit, undervoltage: 10001-10011
// - Cause 00000 at power-on, 10100 bad sleep
// - Window behaviour only in Normal mode
// - Timeout behaviour restarts on any trigger
// - Window code runs timeout until Normal
// - Mode change in Normal forces reset 10000
// - Period codes decode to eight periods
// - Period defaults to 128 ms
// - One period serves both behaviours
// - Each valid control write is a trigger
// - New mode or period applies at once
// - Mode field decode, default timeout or autonomous
// - Bad code abandons write, flags SPI failure
// - Autonomous: timeout in Normal, Standby RXD low
// - Window/timeout codes: timeout in Standby, Sleep
// - Off under forced normal or autonomous development
// - Window: early trigger or overflow resets
// - Timeout overflow sets failure, then resets; in Sleep each overflow wakes instead
`timescale 1ns/1ps
`default_nettype none
module sbc_watchdog_reset_status #(
   parameter int unsigned TICK_CYCLES = sbc_wd_pkg::TICK_CYCLES_DEF
) (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire sbc_wd_pkg::reg_req_t   reg_req,
   input  wire sbc_wd_pkg::chip_mode_t chip_mode,
   input  wire sbc_wd_pkg::cause_ev_t  cause_ev,
   input  wire logic                   rxd_level,
   input  wire logic                   overtemp_warning_in,
   input  wire logic                   forced_normal_enable,
   input  wire logic                   sw_development_enable,
   input  wire logic                   spi_fail_enable,
   input  wire logic                   wdf_clear,
   output var  logic [7:0]             reg_rdata_q,
   output var  logic                   spi_abort_q,
   output var  logic                   spi_fail_event_q,
   output var  logic                   reset_request_q,
   output var  logic                   wd_wake_q,
   output var  logic                   watchdog_failure_flag_q
);
   localparam int unsigned MW = sbc_wd_pkg::MS_W;

   logic [2:0]          mode_q;
   logic [3:0]          period_q;
   logic                defaults_done_q;
   logic                not_yet_normal_q;
   logic [4:0]          cause_q;
   logic [MW-1:0]       elapsed_q;
   sbc_wd_pkg::wd_beh_t beh_q;
   sbc_wd_pkg::wd_beh_t beh;
   logic [1:0]          sync_q;
   logic                rxd_s;
   logic                otw_s;
   logic                tick;
   logic [MW-1:0]       per_ms;
   logic [MW-1:0]       half_ms;
   logic [1:0]          wds;
   logic                wr_ctrl;
   logic                wr_bad;
   logic                wr_illegal;
   logic                wr_good;
   logic                restart;
   logic                overflow;
   logic                early;
   logic                win_ovf;
   logic                to_ovf;
   logic                sleep_ovf;
   logic                to_reset;

   generate
      if (TICK_CYCLES < 2) begin : g_chk
         $error("TICK_CYCLES must be at least 2");
      end
   endgenerate

   // Period in ms; zero marks a code with no meaning
   function automatic logic [MW-1:0] period_ms(input logic [3:0] code);
      case (code)
         4'h8:    period_ms = MW'(8);
         4'h1:    period_ms = MW'(16);
         4'h2:    period_ms = MW'(32);
         4'hB:    period_ms = MW'(64);
         4'h4:    period_ms = MW'(128);
         4'hD:    period_ms = MW'(256);
         4'hE:    period_ms = MW'(1024);
         4'h7:    period_ms = MW'(4096);
         default: period_ms = '0;
      endcase
   endfunction

   function automatic logic mode_valid(input logic [2:0] code);
      mode_valid = (code == sbc_wd_pkg::WMC_AUTO) || (code == sbc_wd_pkg::WMC_TIMEOUT)
                   || (code == sbc_wd_pkg::WMC_WINDOW);
   endfunction

   level_sync #(.WIDTH(2)) u_sync (
      .clk   (clk),
      .reset (reset),
      .d     ({rxd_level, overtemp_warning_in}),
      .q     (sync_q)
   );
   assign rxd_s = sync_q[1];
   assign otw_s = sync_q[0];

   ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk     (clk),
      .reset   (reset),
      .restart (restart),
      .tick_q  (tick)
   );

   // Write classification
   assign wr_ctrl    = reg_req.wr && (reg_req.addr == sbc_wd_pkg::ADDR_WD_CTRL);
   assign wr_bad     = wr_ctrl && !(mode_valid(reg_req.wdata[7:5])
                       && (period_ms(reg_req.wdata[3:0]) != '0));
   assign wr_illegal = wr_ctrl && !wr_bad && (chip_mode == sbc_wd_pkg::CM_NORMAL)
                       && (reg_req.wdata[7:5] != mode_q);
   assign wr_good    = wr_ctrl && !wr_bad && !wr_illegal;

   // Behaviour selection
   always_comb begin
      beh = sbc_wd_pkg::WD_OFF;
      if (!forced_normal_enable) begin
         case (mode_q)
            sbc_wd_pkg::WMC_WINDOW: begin
               if (chip_mode == sbc_wd_pkg::CM_NORMAL) begin
                  beh = sbc_wd_pkg::WD_WINDOW;
               end else if (chip_mode == sbc_wd_pkg::CM_STANDBY
                            || chip_mode == sbc_wd_pkg::CM_SLEEP) begin
                  beh = sbc_wd_pkg::WD_TIMEOUT;
               end
            end
            sbc_wd_pkg::WMC_TIMEOUT: begin
               if (chip_mode == sbc_wd_pkg::CM_NORMAL || chip_mode == sbc_wd_pkg::CM_STANDBY
                   || chip_mode == sbc_wd_pkg::CM_SLEEP) begin
                  beh = sbc_wd_pkg::WD_TIMEOUT;
               end
            end
            sbc_wd_pkg::WMC_AUTO: begin
               if (!sw_development_enable) begin
                  if (chip_mode == sbc_wd_pkg::CM_NORMAL
                      || (chip_mode == sbc_wd_pkg::CM_STANDBY && !rxd_s)) begin
                     beh = sbc_wd_pkg::WD_TIMEOUT;
                  end
               end
            end
            default: beh = sbc_wd_pkg::WD_OFF;
         endcase
      end
   end

   // Same period for both behaviours, halves judged in ms
   assign per_ms  = period_ms(period_q);
   assign half_ms = per_ms >> 1;

   // A behaviour change also restarts so a new mode starts on a full period
   assign restart   = wr_good || (beh != beh_q);
   assign overflow  = (beh != sbc_wd_pkg::WD_OFF) && tick && (elapsed_q == per_ms - MW'(1));
   assign early     = wr_good && (beh == sbc_wd_pkg::WD_WINDOW) && (elapsed_q < half_ms);
   assign win_ovf   = overflow && (beh == sbc_wd_pkg::WD_WINDOW);
   assign to_ovf    = overflow && (beh == sbc_wd_pkg::WD_TIMEOUT);
   assign sleep_ovf = to_ovf && (chip_mode == sbc_wd_pkg::CM_SLEEP);
   assign to_reset  = to_ovf && !sleep_ovf && watchdog_failure_flag_q;

   always_comb begin
      if (beh == sbc_wd_pkg::WD_OFF) begin
         wds = sbc_wd_pkg::WDS_OFF;
      end else if (elapsed_q < half_ms) begin
         wds = sbc_wd_pkg::WDS_FIRST;
      end else begin
         wds = sbc_wd_pkg::WDS_SECOND;
      end
   end

   // Millisecond timer
   always_ff @(posedge clk) begin
      if (reset) begin
         elapsed_q <= '0;
         beh_q     <= sbc_wd_pkg::WD_OFF;
      end else begin
         beh_q <= beh;
         if (beh == sbc_wd_pkg::WD_OFF || restart || overflow) begin
            elapsed_q <= '0;
         end else if (tick) begin
            elapsed_q <= elapsed_q + MW'(1);
         end
      end
   end

   // Control register; development default is taken just after release
   always_ff @(posedge clk) begin
      if (reset) begin
         mode_q          <= sbc_wd_pkg::WMC_TIMEOUT;
         period_q        <= sbc_wd_pkg::NWP_DEFAULT;
         defaults_done_q <= 1'b0;
      end else begin
         defaults_done_q <= 1'b1;
         if (wr_good) begin
            mode_q   <= reg_req.wdata[sbc_wd_pkg::MODE_MSB:sbc_wd_pkg::MODE_LSB];
            period_q <= reg_req.wdata[sbc_wd_pkg::PER_MSB:sbc_wd_pkg::PER_LSB];
         end else if (!defaults_done_q && sw_development_enable) begin
            mode_q <= sbc_wd_pkg::WMC_AUTO;
         end
      end
   end

   // Failure flag: an overflow that does not reset beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         watchdog_failure_flag_q <= 1'b0;
      end else if (to_ovf && !to_reset) begin
         watchdog_failure_flag_q <= 1'b1;
      end else if (wdf_clear) begin
         watchdog_failure_flag_q <= 1'b0;
      end
   end

   // Event outputs
   always_ff @(posedge clk) begin
      if (reset) begin
         reset_request_q  <= 1'b0;
         wd_wake_q        <= 1'b0;
         spi_abort_q      <= 1'b0;
         spi_fail_event_q <= 1'b0;
      end else begin
         reset_request_q  <= wr_illegal || early || win_ovf || to_reset;
         wd_wake_q        <= sleep_ovf;
         spi_abort_q      <= wr_bad;
         spi_fail_event_q <= wr_bad && spi_fail_enable;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         not_yet_normal_q <= 1'b1;
      end else if (chip_mode == sbc_wd_pkg::CM_NORMAL) begin
         not_yet_normal_q <= 1'b0;
      end
   end

   // Cause of latest reset; an illegal mode change, then watchdog causes, win over simultaneous others
   always_ff @(posedge clk) begin
      if (reset) begin
         cause_q <= sbc_wd_pkg::CAUSE_POWER_ON;
      end else if (wr_illegal) begin
         cause_q <= sbc_wd_pkg::CAUSE_ILLEGAL_WMC;
      end else if (early) begin
         cause_q <= sbc_wd_pkg::CAUSE_EARLY_TRIG;
      end else if (win_ovf || to_reset) begin
         cause_q <= sbc_wd_pkg::CAUSE_WD_OVF;
      end else if (sleep_ovf) begin
         cause_q <= sbc_wd_pkg::CAUSE_SLEEP_OVF;
      end else if (cause_ev.v1_undervoltage) begin
         cause_q <= sbc_wd_pkg::CAUSE_V1_UV;
      end else if (cause_ev.pin_pulldown) begin
         cause_q <= sbc_wd_pkg::CAUSE_PIN_PULL;
      end else if (cause_ev.overtemp_exit) begin
         cause_q <= sbc_wd_pkg::CAUSE_OT_EXIT;
      end else if (cause_ev.bad_sleep_cmd) begin
         cause_q <= sbc_wd_pkg::CAUSE_BAD_SLEEP;
      end else if (cause_ev.diag_wake) begin
         cause_q <= sbc_wd_pkg::CAUSE_DIAG_WAKE;
      end else if (cause_ev.pin_wake) begin
         cause_q <= sbc_wd_pkg::CAUSE_PIN_WAKE;
      end else if (cause_ev.can_wake) begin
         cause_q <= sbc_wd_pkg::CAUSE_CAN_WAKE;
      end
   end

   // Read data, one cycle after the request; unmapped reads return zero
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            sbc_wd_pkg::ADDR_WD_CTRL:     reg_rdata_q <= {mode_q, 1'b0, period_q};
            sbc_wd_pkg::ADDR_MAIN_STATUS: reg_rdata_q <= {1'b0, otw_s, not_yet_normal_q,
                                                          cause_q};
            sbc_wd_pkg::ADDR_WD_STATUS:   reg_rdata_q <= {4'h0, forced_normal_enable,
                                                          sw_development_enable, wds};
            default:                      reg_rdata_q <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   AST_OTW_READ: assert property (reg_req.rd && reg_req.addr == sbc_wd_pkg::ADDR_MAIN_STATUS
      |=> reg_rdata_q[sbc_wd_pkg::OTW_BIT] == $past(otw_s))
      else $error("overtemperature status bit wrong");
   AST_NYN_CLEAR: assert property (chip_mode == sbc_wd_pkg::CM_NORMAL
      |=> !not_yet_normal_q ##1 !not_yet_normal_q)
      else $error("not-yet-normal flag still set after Normal");
   AST_ILLEGAL_WMC: assert property (wr_illegal
      |=> reset_request_q && cause_q == sbc_wd_pkg::CAUSE_ILLEGAL_WMC && $stable(mode_q))
      else $error("mode change in Normal not punished");
   AST_EARLY_TRIG: assert property (early && !wr_illegal
      |=> reset_request_q && cause_q == sbc_wd_pkg::CAUSE_EARLY_TRIG)
      else $error("early window trigger did not reset");
   AST_BAD_CODE: assert property (wr_bad
      |=> spi_abort_q && $stable(mode_q) && $stable(period_q) && !reset_request_q)
      else $error("invalid code was not abandoned");
   AST_TRIG_RESTART: assert property (wr_good && !early
      |=> elapsed_q == '0 && !reset_request_q)
      else $error("valid write did not restart timer");
   AST_WDF_FIRST: assert property (to_ovf && !sleep_ovf && !watchdog_failure_flag_q
      |=> watchdog_failure_flag_q && !reset_request_q)
      else $error("first timeout overflow handled wrongly");
   AST_FNM_OFF: assert property (forced_normal_enable |=> elapsed_q == '0 && !reset_request_q)
      else $error("watchdog running under forced normal");
   AST_WIN_ONLY_NORMAL: assert property (beh == sbc_wd_pkg::WD_WINDOW
      |-> chip_mode == sbc_wd_pkg::CM_NORMAL && mode_q == sbc_wd_pkg::WMC_WINDOW)
      else $error("window behaviour outside Normal");
   AST_NWP_DEFAULT: assert property ($fell(reset) |-> period_q == sbc_wd_pkg::NWP_DEFAULT)
      else $error("period not at default after reset");

   COV_EARLY: cover property (early);
   COV_WIN_OK: cover property (wr_good && beh == sbc_wd_pkg::WD_WINDOW && !early);
   COV_WDF_SET: cover property (to_ovf && !to_reset && !sleep_ovf);
   COV_SLEEP_WAKE: cover property (sleep_ovf ##1 wd_wake_q);
endmodule // sbc_watchdog_reset_status
`default_nettype wire

// ==== verif/spi_host_model.sv ====
// Host model issuing register reads and writes on the register port
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input  wire logic                 clk,
   input  wire logic [7:0]           reg_rdata,
   output var  sbc_wd_pkg::reg_req_t reg_req
);
   initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 7'h7F, wdata: 8'h5A};

   // Valid control writes are triggers; callers change the mode in standby, except one illegal change in normal
   task wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      // Released lines inverted so stale values cannot pass
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
      #1;
   endtask

   task rd(input logic [6:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      #1;
      v = reg_rdata;
   endtask
endmodule // spi_host_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the watchdog and main status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                   clk;
   logic                   reset;
   sbc_wd_pkg::reg_req_t   reg_req;
   sbc_wd_pkg::chip_mode_t chip_mode;
   sbc_wd_pkg::cause_ev_t  cause_ev;
   logic                   rxd_level, otw_in, fnm, sdm, fail_en, wdf_clear;
   logic [7:0]             rdata, d;
   logic                   spi_abort, fail_ev, rst_req, wake, watchdog_failure_flag;
   int                     fail_count, compares, n;
   wire logic [2:0]        outs = {wake, rst_req, watchdog_failure_flag};
   logic [7:0]             per_tbl [0:7] = '{8'h48, 8'h41, 8'h42, 8'h4B, 8'h44, 8'h4D, 8'h4E, 8'h47};
   logic [7:0]             cause_tbl [0:6] = '{8'h14, 8'h13, 8'h12, 8'h11, 8'h0D, 8'h04, 8'h01};

   // Short tick so an 8 ms period is 32 clocks
   sbc_watchdog_reset_status #(.TICK_CYCLES(4)) i_sbc_watchdog_reset_status (
      .clk(clk), .reset(reset), .reg_req(reg_req), .chip_mode(chip_mode),
      .cause_ev(cause_ev), .rxd_level(rxd_level), .overtemp_warning_in(otw_in),
      .forced_normal_enable(fnm), .sw_development_enable(sdm), .spi_fail_enable(fail_en),
      .wdf_clear(wdf_clear), .reg_rdata_q(rdata), .spi_abort_q(spi_abort),
      .spi_fail_event_q(fail_ev), .reset_request_q(rst_req), .wd_wake_q(wake),
      .watchdog_failure_flag_q(watchdog_failure_flag));
   spi_host_model i_spi_host_model (.clk(clk), .reg_rdata(rdata), .reg_req(reg_req));

   always #25 clk = ~clk;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task rdchk(input logic [6:0] a, input logic [7:0] exp);
      i_spi_host_model.rd(a, d);
      chk(d, exp);
   endtask
   task wait_hi(input int w, input int lim);
      n = 0;
      while (outs[w] !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task inrange(input int lo, input int hi);
      chk(8'(n >= lo && n <= hi), 8'h01);
   endtask
   task mode(input sbc_wd_pkg::chip_mode_t m);
      @(posedge clk);
      chip_mode <= m;
   endtask
   task clr;
      @(posedge clk);
      wdf_clear <= 1'b1;
      @(posedge clk);
      wdf_clear <= 1'b0;
   endtask

   task t_reset_values;
      rdchk(7'h03, 8'h20);
      rdchk(7'h00, 8'h44);
      rdchk(7'h7F, 8'h00);
      otw_in <= 1'b1;
      repeat (4) @(posedge clk);
      rdchk(7'h03, 8'h60);
      otw_in <= 1'b0;
      repeat (4) @(posedge clk);
      rdchk(7'h03, 8'h20);
      $display("test reset_values done");
   endtask

   task t_codes;
      i_spi_host_model.wr(7'h00, 8'h64);
      chk({spi_abort, fail_ev}, 8'h03);
      fail_en <= 1'b0;
      i_spi_host_model.wr(7'h00, 8'h64);
      chk({spi_abort, fail_ev}, 8'h02);
      fail_en <= 1'b1;
      i_spi_host_model.wr(7'h00, 8'h49);
      chk({spi_abort, fail_ev}, 8'h03);
      rdchk(7'h00, 8'h44);
      for (int i = 0; i < 8; i++) begin
         i_spi_host_model.wr(7'h00, per_tbl[i]);
         chk(8'(spi_abort), 8'h00);
         rdchk(7'h00, per_tbl[i]);
      end
      $display("test codes done");
   endtask

   task t_timeout;
      i_spi_host_model.wr(7'h00, 8'h48);
      repeat (3) begin
         repeat (20) @(posedge clk);
         i_spi_host_model.wr(7'h00, 8'h48);
      end
      chk(8'(watchdog_failure_flag), 8'h00);
      wait_hi(0, 40);
      inrange(30, 34);
      chk(8'(rst_req), 8'h00);
      wait_hi(1, 40);
      inrange(30, 34);
      rdchk(7'h03, 8'h2F);
      clr;
      i_spi_host_model.wr(7'h00, 8'h48);
      mode(sbc_wd_pkg::CM_SLEEP);
      wait_hi(2, 40);
      inrange(1, 34);
      chk({rst_req, watchdog_failure_flag}, 8'h01);
      mode(sbc_wd_pkg::CM_STANDBY);
      rdchk(7'h03, 8'h2C);
      $display("test timeout done");
   endtask

   task t_window;
      clr;
      i_spi_host_model.wr(7'h00, 8'h88);
      wait_hi(0, 40);
      inrange(30, 34);
      chk(8'(rst_req), 8'h00);
      clr;
      mode(sbc_wd_pkg::CM_NORMAL);
      rdchk(7'h03, 8'h0C);
      i_spi_host_model.wr(7'h00, 8'h88);
      wait_hi(1, 3);
      inrange(0, 2);
      rdchk(7'h03, 8'h0E);
      mode(sbc_wd_pkg::CM_STANDBY);
      mode(sbc_wd_pkg::CM_NORMAL);
      repeat (22) @(posedge clk);
      i_spi_host_model.wr(7'h00, 8'h88);
      chk(8'(rst_req), 8'h00);
      wait_hi(1, 40);
      inrange(28, 34);
      rdchk(7'h03, 8'h0F);
      i_spi_host_model.wr(7'h00, 8'h48);
      wait_hi(1, 3);
      inrange(0, 2);
      rdchk(7'h03, 8'h10);
      rdchk(7'h00, 8'h88);
      $display("test window done");
   endtask

   task t_causes;
      mode(sbc_wd_pkg::CM_RESET);
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         cause_ev <= sbc_wd_pkg::cause_ev_t'(7'h01 << i);
         @(posedge clk);
         cause_ev <= '0;
         rdchk(7'h03, cause_tbl[i]);
      end
      rdchk(7'h05, 8'h00);
      $display("test causes done");
   endtask

   task t_off;
      clr;
      mode(sbc_wd_pkg::CM_STANDBY);
      fnm <= 1'b1;
      i_spi_host_model.wr(7'h00, 8'h48);
      repeat (80) @(posedge clk);
      chk(8'(watchdog_failure_flag), 8'h00);
      rdchk(7'h05, 8'h08);
      fnm <= 1'b0;
      rxd_level <= 1'b1;
      i_spi_host_model.wr(7'h00, 8'h28);
      repeat (80) @(posedge clk);
      chk(8'(watchdog_failure_flag), 8'h00);
      rxd_level <= 1'b0;
      wait_hi(0, 60);
      inrange(1, 40);
      rdchk(7'h05, 8'h01);
      clr;
      sdm <= 1'b1;
      repeat (80) @(posedge clk);
      chk(8'(watchdog_failure_flag), 8'h00);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      rdchk(7'h00, 8'h24);
      rdchk(7'h03, 8'h20);
      $display("test off_modes done");
   endtask

   task finish_test;
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Tests need under a thousand clocks; twenty thousand means a hang
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      finish_test;
   end

   initial begin
      clk = 0; reset = 1; chip_mode = sbc_wd_pkg::CM_STANDBY; cause_ev = '0;
      rxd_level = 1; otw_in = 0; fnm = 0; sdm = 0; fail_en = 1; wdf_clear = 0;
      fail_count = 0; compares = 0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset_values;
      t_codes;
      t_timeout;
      t_window;
      t_causes;
      t_off;
      finish_test;
   end
endmodule // tb_top
`default_nettype wire
